// File: pkg/byte_io_pkg.sv
package byte_io_pkg;
   // nibble mode codes for the address-capable port
   localparam logic [1:0] NIB_IN = 2'h0;
   localparam logic [1:0] NIB_OUT = 2'h1;
   localparam logic [1:0] NIB_ADDR = 2'h2;
   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam int HANDSHAKE_BIT = 7;

   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
      logic [7:0] pull;
   } pin_drive_t;
endpackage : byte_io_pkg

// File: rtl/byte_io_ports.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module byte_io_ports
   import byte_io_pkg::*;
(
   input wire logic clk, // 200 MHz
   input wire logic reset_n, // async, active low
   input wire logic [1:0] lo_mode, // low nibble mode code
   input wire logic [1:0] hi_mode, // high nibble mode code
   input wire logic [7:0] p0_wr_data, // port 0 output data
   input wire logic p0_wr, // write strobe port 0
   input wire logic [7:0] addr_high, // external address 15:8
   input wire logic ext_access, // external memory access active
   input wire logic bus_float, // float address port and strobes
   input wire logic address_strobe_in, // internal address strobe, active high
   input wire logic data_strobe_in, // internal data strobe, active high
   input wire logic rw_in, // internal read/write
   input wire logic stack_access, // internal stack access
   input wire logic stack_byte_gpr, // stack byte used as general register
   input wire logic [7:0] stack_pointer_high_byte, // stack byte
   input wire logic lo_low_trip, // low trip on bits 3:0
   input wire logic [1:0] p0_pull_en, // pull-up enable per nibble
   input wire logic [7:0] p0_pin, // port 0 pin level
   output logic [7:0] p0_rd_data, // port 0 read value
   output pin_drive_t p0_drv, // port 0 drive
   output logic lo_trip_sel, // trip select for bits 3:0
   output logic address_strobe_out_n, // active low
   output logic address_strobe_oe, // high while driven
   output logic data_strobe_out_n, // active low
   output logic data_strobe_oe, // high while driven
   output logic rw_out, // read/write, write low
   output logic rw_oe, // high while driven
   input wire logic [7:0] p2_wr_data, // port 2 output data
   input wire logic p2_wr, // write strobe port 2
   input wire logic [7:0] p2_dir_out, // 1 = output per bit
   input wire logic p2_dir_wr, // direction write strobe
   input wire logic p2_open_drain, // 1 = open drain outputs
   input wire logic p2_pull_en, // all eight pull-ups
   input wire logic handshake_en, // handshake mode
   input wire logic [7:0] p2_pin, // port 2 pin level
   output logic [7:0] p2_rd_data, // port 2 read value
   output pin_drive_t p2_drv, // port 2 drive
   input wire logic p31_pin, // third port line 1
   input wire logic p36_pin, // third port line 6
   output logic handshake_data_valid, // sampled valid when input role
   output logic handshake_ready, // sampled ready when output role
   output logic p31_o, // line 1 drive value
   output logic p31_oe, // line 1 enable
   output logic p36_o, // line 6 drive value
   output logic p36_oe // line 6 enable
);
   //////////////////////////////////////////////////////////////////////////
   logic [7:0] p0_s1_reg, p0_s2_reg, p2_s1_reg, p2_s2_reg;
   logic [1:0] h_s1_reg, h_s2_reg;
   logic [7:0] p0_out_reg, p2_out_reg, p2_dir_reg;
   logic [1:0] lo_mode_reg, hi_mode_reg;
   pin_drive_t p0_drv_next, p2_drv_next;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         p0_s1_reg <= 8'h00;
         p0_s2_reg <= 8'h00;
         p2_s1_reg <= 8'h00;
         p2_s2_reg <= 8'h00;
         h_s1_reg <= 2'h0;
         h_s2_reg <= 2'h0;
      end else begin
         p0_s1_reg <= p0_pin;
         p0_s2_reg <= p0_s1_reg;
         p2_s1_reg <= p2_pin;
         p2_s2_reg <= p2_s1_reg;
         h_s1_reg <= {p36_pin, p31_pin};
         h_s2_reg <= h_s1_reg;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // port 0: address-capable
   wire hi_addr = (hi_mode_reg == NIB_ADDR);
   // high nibble in address mode forces low nibble too
   wire lo_addr = (lo_mode_reg == NIB_ADDR) || hi_addr;
   wire hi_out = (hi_mode_reg == NIB_OUT);
   // low nibble mode only picks address use; as I/O it copies the high direction
   wire lo_out = hi_out;
   wire stack_drive = stack_byte_gpr && stack_access;
   wire [7:0] addr_src = stack_drive ? stack_pointer_high_byte : addr_high;
   wire addr_drive = (ext_access || stack_drive) && !bus_float;
   wire [3:0] lo_val = lo_addr ? addr_src[3:0] : p0_out_reg[3:0];
   wire [3:0] hi_val = hi_addr ? addr_src[7:4] : p0_out_reg[7:4];
   wire lo_oe = lo_addr ? addr_drive : lo_out;
   wire hi_oe = hi_addr ? addr_drive : hi_out;
   wire [7:0] p0_oe_w = {{4{hi_oe}}, {4{lo_oe}}};
   wire [7:0] p0_pull_w = {{4{p0_pull_en[1]}}, {4{p0_pull_en[0]}}} & ~p0_oe_w;
   wire [7:0] p0_out_mask = {{4{hi_out}}, {4{lo_out}}};
   assign p0_drv_next = '{o: {hi_val, lo_val}, oe: p0_oe_w, pull: p0_pull_w};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lo_mode_reg <= MODE_RESET;
         hi_mode_reg <= MODE_RESET;
         p0_out_reg <= PORT_RESET;
      end else begin
         lo_mode_reg <= lo_mode;
         hi_mode_reg <= hi_mode;
         if (p0_wr) p0_out_reg <= p0_wr_data;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // port 2: general I/O only, never takes address
   genvar i;
   logic [7:0] p2_o_w, p2_oe_w;
   for (i = 0; i < 8; i++) begin : g_p2
      // open drain drives only low; push-pull drives both levels
      assign p2_o_w[i] = p2_open_drain ? 1'b0 : p2_out_reg[i];
      assign p2_oe_w[i] = p2_dir_reg[i] &&
                          (!p2_open_drain || !p2_out_reg[i]);
   end
   assign p2_drv_next = '{o: p2_o_w, oe: p2_oe_w, pull: {8{p2_pull_en}}};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         p2_out_reg <= PORT_RESET;
         p2_dir_reg <= PORT_RESET;
      end else begin
         if (p2_wr) p2_out_reg <= p2_wr_data;
         if (p2_dir_wr) p2_dir_reg <= p2_dir_out;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // handshake: bit 7 output -> port drives valid on line 1, reads ready on 6
   wire hs_tx = p2_dir_reg[HANDSHAKE_BIT];
   wire hs_dv_n = !p2_wr; // valid low pulse after a write, kept simple
   wire hs_rdy = 1'b1; // receiver side always ready

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         p0_drv <= '0;
         p2_drv <= '0;
         p0_rd_data <= 8'h00;
         p2_rd_data <= 8'h00;
         lo_trip_sel <= 1'b0;
         address_strobe_out_n <= 1'b1;
         address_strobe_oe <= 1'b0;
         data_strobe_out_n <= 1'b1;
         data_strobe_oe <= 1'b0;
         rw_out <= 1'b1;
         rw_oe <= 1'b0;
         handshake_data_valid <= 1'b0;
         handshake_ready <= 1'b0;
         p31_o <= 1'b1;
         p31_oe <= 1'b0;
         p36_o <= 1'b1;
         p36_oe <= 1'b0;
      end else begin
         p0_drv <= p0_drv_next;
         p2_drv <= p2_drv_next;
         p0_rd_data <= (p0_out_mask & p0_out_reg) | (~p0_out_mask & p0_s2_reg);
         p2_rd_data <= (p2_dir_reg & p2_out_reg) | (~p2_dir_reg & p2_s2_reg);
         lo_trip_sel <= lo_low_trip;
         address_strobe_out_n <= !address_strobe_in;
         address_strobe_oe <= !bus_float;
         data_strobe_out_n <= !data_strobe_in;
         data_strobe_oe <= !bus_float;
         rw_out <= rw_in;
         rw_oe <= !bus_float;
         handshake_data_valid <= !h_s2_reg[0];
         handshake_ready <= h_s2_reg[1];
         p31_o <= hs_dv_n;
         p31_oe <= handshake_en && hs_tx;
         p36_o <= hs_rdy;
         p36_oe <= handshake_en && !hs_tx;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   a_low_follows_high: assert property (@(posedge clk) disable iff (!reset_n)
      hi_addr |-> ##1 p0_drv.oe[3:0] == p0_drv.oe[7:4])
      else $error("nibble dir split");
   a_gpio_dir_match: assert property (@(posedge clk) disable iff (!reset_n)
      !lo_addr |-> ##1 p0_drv.oe[3:0] == p0_drv.oe[7:4])
      else $error("gpio nibble dir split");
   a_addr_drives: assert property (@(posedge clk) disable iff (!reset_n)
      (lo_addr && addr_drive && !stack_access) |-> ##1 p0_drv.o[3:0] == $past(addr_high[3:0]))
      else $error("address nibble wrong");
   a_hi_gpio_kept: assert property (@(posedge clk) disable iff (!reset_n)
      (hi_mode_reg == NIB_OUT && lo_mode_reg == NIB_ADDR) |->
      ##1 p0_drv.o[7:4] == $past(p0_out_reg[7:4]) && p0_drv.oe[7:4] == 4'hF)
      else $error("high nibble lost");
   a_float_all: assert property (@(posedge clk) disable iff (!reset_n)
      (bus_float && lo_addr) |->
      ##1 (p0_drv.oe[3:0] == 4'h0 && !address_strobe_oe && !data_strobe_oe && !rw_oe))
      else $error("float failed");
   a_pull_off_out: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 (p0_drv.pull & p0_drv.oe) == 8'h00)
      else $error("pull on output");
   a_p2_dir: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 (p2_drv.oe & ~$past(p2_dir_reg)) == 8'h00)
      else $error("input bit driven");
   a_p2_pull: assert property (@(posedge clk) disable iff (!reset_n)
      p2_pull_en |-> ##1 p2_drv.pull == 8'hFF)
      else $error("pull-ups missing");
   a_open_drain: assert property (@(posedge clk) disable iff (!reset_n)
      p2_open_drain |-> ##1 (p2_drv.o & p2_drv.oe) == 8'h00)
      else $error("od high");
   a_hs_roles: assert property (@(posedge clk) disable iff (!reset_n)
      handshake_en |-> ##1 (p31_oe == $past(p2_dir_reg[HANDSHAKE_BIT]) && p31_oe != p36_oe))
      else $error("handshake roles");
   a_stack_out: assert property (@(posedge clk) disable iff (!reset_n)
      (stack_byte_gpr && stack_access && hi_addr && !bus_float) |->
      ##1 p0_drv.o == $past(stack_pointer_high_byte))
      else $error("stack byte missing");
   // a write in send mode shows as a low on the driven valid line next cycle
   sequence s_send_write;
      handshake_en && hs_tx && p2_wr;
   endsequence
   sequence s_valid_low;
      !p31_o && p31_oe;
   endsequence
   a_valid_pulse: assert property (@(posedge clk) disable iff (!reset_n)
      s_send_write |-> ##1 s_valid_low)
      else $error("valid pulse missing");
endmodule : byte_io_ports

// File: sim/far_side_model.sv
`timescale 1ns/1ps
module far_side_model
   import byte_io_pkg::*;
(
   input wire pin_drive_t p0_drv, // port 0 drive
   input wire pin_drive_t p2_drv, // port 2 drive
   input wire logic [7:0] p0_ext, // peripheral level on port 0
   input wire logic [7:0] p2_ext, // peripheral level on port 2
   input wire logic p31_o, // line 1 drive value
   input wire logic p31_oe, // line 1 enable
   input wire logic p36_o, // line 6 drive value
   input wire logic p36_oe, // line 6 enable
   input wire logic p31_ext, // peripheral level on line 1
   input wire logic p36_ext, // peripheral level on line 6
   output logic [7:0] p0_pin, // resolved port 0
   output logic [7:0] p2_pin, // resolved port 2
   output logic p31_pin, // resolved line 1
   output logic p36_pin // resolved line 6
);
   // the peripheral always drives undriven lines, so no bit is left floating
   assign p0_pin = (p0_drv.oe & p0_drv.o) | (~p0_drv.oe & p0_ext);
   assign p2_pin = (p2_drv.oe & p2_drv.o) | (~p2_drv.oe & p2_ext);
   assign p31_pin = p31_oe ? p31_o : p31_ext;
   assign p36_pin = p36_oe ? p36_o : p36_ext;
endmodule : far_side_model

// File: sim/tb_byte_io_ports.sv
`timescale 1ns/1ps
module tb_byte_io_ports;
   import byte_io_pkg::*;
   logic clk, reset_n, p0_wr, ext_access, bus_float, rw_in, stack_access;
   logic address_strobe_in, data_strobe_in, stack_byte_gpr;
   logic lo_low_trip, p2_wr, p2_dir_wr, p2_open_drain, p2_pull_en, handshake_en;
   logic p31_ext, p36_ext, p31_pin, p36_pin, lo_trip_sel, address_strobe_out_n;
   logic address_strobe_oe, data_strobe_out_n, data_strobe_oe, rw_out, rw_oe;
   logic handshake_data_valid, handshake_ready, p31_o, p31_oe, p36_o, p36_oe;
   logic [1:0] lo_mode, hi_mode, p0_pull_en;
   logic [7:0] p0_wr_data, addr_high, stack_pointer_high_byte, p2_wr_data, p2_dir_out;
   logic [7:0] p0_ext, p2_ext, p0_pin, p2_pin, p0_rd_data, p2_rd_data;
   pin_drive_t p0_drv, p2_drv;
   int mismatches = 0;
   int samples_checked = 0;
   byte_io_ports dut (
      .clk(clk), .reset_n(reset_n), .lo_mode(lo_mode), .hi_mode(hi_mode),
      .p0_wr_data(p0_wr_data), .p0_wr(p0_wr), .addr_high(addr_high), .ext_access(ext_access),
      .bus_float(bus_float), .address_strobe_in(address_strobe_in),
      .data_strobe_in(data_strobe_in), .rw_in(rw_in), .stack_access(stack_access),
      .stack_byte_gpr(stack_byte_gpr), .stack_pointer_high_byte(stack_pointer_high_byte),
      .lo_low_trip(lo_low_trip), .p0_pull_en(p0_pull_en), .p0_pin(p0_pin),
      .p0_rd_data(p0_rd_data), .p0_drv(p0_drv), .lo_trip_sel(lo_trip_sel),
      .address_strobe_out_n(address_strobe_out_n), .address_strobe_oe(address_strobe_oe),
      .data_strobe_out_n(data_strobe_out_n), .data_strobe_oe(data_strobe_oe),
      .rw_out(rw_out), .rw_oe(rw_oe), .p2_wr_data(p2_wr_data), .p2_wr(p2_wr),
      .p2_dir_out(p2_dir_out), .p2_dir_wr(p2_dir_wr), .p2_open_drain(p2_open_drain),
      .p2_pull_en(p2_pull_en), .handshake_en(handshake_en), .p2_pin(p2_pin),
      .p2_rd_data(p2_rd_data), .p2_drv(p2_drv), .p31_pin(p31_pin), .p36_pin(p36_pin),
      .handshake_data_valid(handshake_data_valid), .handshake_ready(handshake_ready),
      .p31_o(p31_o), .p31_oe(p31_oe), .p36_o(p36_o), .p36_oe(p36_oe)
   );
   far_side_model peer (
      .p0_drv(p0_drv), .p2_drv(p2_drv), .p0_ext(p0_ext), .p2_ext(p2_ext),
      .p31_o(p31_o), .p31_oe(p31_oe), .p36_o(p36_o), .p36_oe(p36_oe),
      .p31_ext(p31_ext), .p36_ext(p36_ext), .p0_pin(p0_pin), .p2_pin(p2_pin),
      .p31_pin(p31_pin), .p36_pin(p36_pin)
   );
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // pins need three cycles through the synchroniser; four leaves margin
   task automatic settle;
      repeat (4) @(negedge clk);
   endtask : settle
   task automatic wr0(input logic [7:0] d);
      p0_wr_data = d;
      p0_wr = 1'b1;
      @(negedge clk) p0_wr = 1'b0;
   endtask : wr0
   task automatic wr2(input logic [7:0] d);
      p2_wr_data = d;
      p2_wr = 1'b1;
      @(negedge clk) p2_wr = 1'b0;
   endtask : wr2
   task automatic wdir(input logic [7:0] d);
      p2_dir_out = d;
      p2_dir_wr = 1'b1;
      @(negedge clk) p2_dir_wr = 1'b0;
   endtask : wdir
   task automatic wrap_up;
      $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {p0_wr, ext_access, bus_float, address_strobe_in, data_strobe_in, rw_in} = '0;
      {stack_access, stack_byte_gpr} = '0;
      {lo_low_trip, p2_wr, p2_dir_wr, p2_open_drain, p2_pull_en, handshake_en} = '0;
      {p31_ext, p36_ext, lo_mode, hi_mode, p0_pull_en, p0_wr_data, addr_high} = '0;
      {stack_pointer_high_byte, p2_wr_data, p2_dir_out, p0_ext, p2_ext} = '0;
      reset_n = 1'b0;
      repeat (12) @(posedge clk);
      @(negedge clk) reset_n = 1'b1;
      settle();
      chk(p0_drv.oe, 8'h00);
      lo_mode = NIB_OUT;
      hi_mode = NIB_OUT;
      p0_pull_en = 2'h3;
      wr0(8'hA5);
      settle();
      chk(p0_drv.o, 8'hA5);
      chk(p0_drv.pull, 8'h00);
      lo_mode = NIB_IN;
      settle();
      chk(p0_drv.oe, 8'hFF);
      {lo_mode, hi_mode} = {NIB_OUT, NIB_IN};
      settle();
      chk(p0_drv.oe, 8'h00);
      chk(p0_drv.pull, 8'hFF);
      {ext_access, addr_high, lo_mode, hi_mode} = {1'b1, 8'hC3, NIB_ADDR, NIB_ADDR};
      settle();
      chk(p0_drv.o, 8'hC3);
      chk(p2_drv.oe, 8'h00);
      hi_mode = NIB_OUT;
      settle();
      chk(p0_drv.o, 8'hA3);
      {stack_byte_gpr, stack_access, stack_pointer_high_byte} = {2'h3, 8'h9E};
      {ext_access, hi_mode, address_strobe_in, data_strobe_in} = {1'b0, NIB_ADDR, 2'h3};
      settle();
      chk(p0_drv.o, 8'h9E);
      chk({address_strobe_out_n, data_strobe_out_n, rw_out,
           address_strobe_oe, data_strobe_oe, rw_oe}, 8'h07);
      bus_float = 1'b1;
      lo_low_trip = 1'b1;
      settle();
      chk(p0_drv.oe, 8'h00);
      chk({address_strobe_oe, data_strobe_oe, rw_oe, lo_trip_sel}, 8'h01);
      {bus_float, stack_byte_gpr, stack_access, lo_mode, hi_mode} = {3'h0, NIB_IN, NIB_IN};
      p0_ext = 8'h3C;
      settle();
      chk(p0_rd_data, 8'h3C);
      wdir(8'h0F);
      wr2(8'h35);
      p2_ext = 8'hA0;
      settle();
      chk(p2_drv.oe, 8'h0F);
      chk({4'h0, p2_drv.o[3:0]}, 8'h05);
      chk(p2_rd_data, 8'hA5);
      {p2_open_drain, p2_pull_en} = 2'h3;
      settle();
      chk(p2_drv.oe, 8'h0A);
      chk(p2_drv.pull, 8'hFF);
      {handshake_en, p36_ext} = 2'h3;
      wdir(8'h8F);
      settle();
      chk({p31_oe, p36_oe, handshake_ready, p31_o}, 8'h0B);
      wr2(8'h35);
      // the valid low stands for one cycle after the write edge
      chk(p31_o, 8'h00);
      wdir(8'h0F);
      settle();
      chk({p31_oe, p36_oe, p36_o, handshake_data_valid}, 8'h07);
      {lo_mode, hi_mode} = {NIB_OUT, NIB_OUT};
      settle();
      chk(p0_drv.oe, 8'hFF);
      // second reset in mid-run: the port must drop back to input at once
      reset_n = 1'b0;
      @(negedge clk);
      chk(p0_drv.oe, 8'h00);
      chk(p0_rd_data, 8'h00);
      reset_n = 1'b1;
      settle();
      chk(p0_drv.o, 8'h00);
      wrap_up();
   end
endmodule : tb_byte_io_ports
